// ==== hdl/rsc_reset_source_control.sv ====
/*
  Reset source control: external pin, watchdog time-out and brownout.
  Assumes all inputs except the reset pin are synchronous to clk and that
  the option bit is a static level from non-volatile storage.
  The hold and pin counters are eight bits wide, so HOLD_CYCLES and
  PIN_LOW_CYCLES must stay at or below 256; larger values would wrap.
  A time-out that arrives while a reset is running is dropped on purpose.
*/
// Summary of operation
// - Watchdog time-out in normal or halt mode resets when option is one.
// - Unprogrammed option bit reads as one.
// - Option zero: time-out raises interrupt, no reset.
// - Watchdog reset sets watchdog cause flag.
// - Reset may begin after three pin cycles.
// - Brownout recovery always yields power-on reset.
`timescale 1ns/1ns
module rsc_reset_source_control
    import rsc_pkg::*;
#(
    parameter int unsigned PIN_LOW_CYCLES = rsc_pkg::RSC_PIN_LOW_CYCLES,
    parameter int unsigned HOLD_CYCLES = rsc_pkg::RSC_HOLD_CYCLES
)
(
    input wire logic clk,
    input wire logic srst,
    input wire rsc_pkg::rsc_sources_t sources,
    input wire logic option_programmed,
    input wire logic option_value,
    input wire logic cause_clear,
    output logic system_reset,
    output logic power_on_reset,
    output logic watchdog_irq,
    output rsc_pkg::rsc_cause_t reset_cause_register
);
    import rsc_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------

    // Stage 0 is read only by stage 1, so metastability stays contained.
    logic [RSC_SYNC_STAGES-1:0] sync;
    logic [RSC_SYNC_STAGES-1:0] next_sync;

    // Shift the raw pin in; reset fills with the idle high level.
    always_comb
    begin
        next_sync = {sync[RSC_SYNC_STAGES-2:0], sources.ext_reset_n};
        if (srst)
        begin
            next_sync = '1;
        end
    end

    // Plain shift register; the clear comes in through next_sync, so the
    // pin reads idle high for the first cycles after reset.
    always_ff @(posedge clk)
    begin
        sync <= next_sync;
    end

    // The synchronised pin, inverted: high while the active-low pin is low.
    logic pin_low;
    assign pin_low = ~sync[RSC_SYNC_STAGES-1];

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------

    // Option bit as seen by logic; unprogrammed storage reads as one.
    // The option is a static level, so it needs no synchroniser.
    logic wdt_option;
    assign wdt_option = option_programmed ? option_value
                                          : RSC_OPTION_UNPROGRAMMED;

    // State, counters and the next values of the registered outputs.
    // Each group is computed below and only registered at the bottom.
    rsc_state_t state;
    rsc_state_t next_state;
    logic [7:0] pin_cnt;         // Consecutive synchronised low cycles.
    logic [7:0] next_pin_cnt;
    logic [7:0] hold_cnt;        // Remaining reset hold cycles.
    logic [7:0] next_hold_cnt;
    logic brownout_seen;         // Set by brownout or power-up reset; cleared on POR exit.
    logic next_brownout_seen;
    logic next_system_reset;
    logic next_power_on_reset;
    logic next_watchdog_irq;
    rsc_cause_t next_cause;
    logic pin_trip;              // Pin low long enough to start a reset.
    logic wdt_reset;             // Time-out that must reset the system.

    // Pin trips at the third synchronised low cycle; a four-cycle pulse
    // from outside always reaches this even with synchroniser skew.
    assign pin_trip = pin_low
        && (pin_cnt >= 8'(PIN_LOW_CYCLES - 1));
    assign wdt_reset = sources.watchdog_timeout && sources.normal_or_halt
        && wdt_option;

    // Next-state logic. A brownout outranks every other source because
    // recovery from it must look exactly like a cold start.
    always_comb
    begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        next_brownout_seen = brownout_seen;
        next_cause = reset_cause_register;
        next_watchdog_irq = 1'b0;
        next_pin_cnt = 8'h00;
        // Count low cycles and saturate so the counter never wraps.
        if (pin_low)
        begin
            next_pin_cnt = (pin_cnt == 8'hFF) ? pin_cnt : pin_cnt + 8'h01;
        end
        // Software clear first, so a new cause in this cycle wins.
        if (cause_clear)
        begin
            next_cause = '0;
        end
        unique case (state)
            RSC_RUN:
            begin
                if (sources.brownout_condition)
                begin
                    next_state = RSC_POR;
                    next_brownout_seen = 1'b1;
                    // Load the full hold so even a one-cycle dip gets a
                    // complete power-on reset once the supply is back.
                    next_hold_cnt = 8'(HOLD_CYCLES - 1);
                end
                else if (wdt_reset)
                begin
                    next_state = RSC_SYS_RESET;
                    next_hold_cnt = 8'(HOLD_CYCLES - 1);
                    next_cause.watchdog_cause_flag = 1'b1;
                end
                else if (pin_trip)
                begin
                    next_state = RSC_SYS_RESET;
                    next_hold_cnt = 8'(HOLD_CYCLES - 1);
                    next_cause.external = 1'b1;
                end
                else if (sources.watchdog_timeout && !wdt_option)
                begin
                    // Interrupt only; the system keeps running.
                    next_watchdog_irq = 1'b1;
                end
            end
            RSC_SYS_RESET:
            begin
                // A brownout during a system reset escalates it.
                if (sources.brownout_condition)
                begin
                    next_state = RSC_POR;
                    next_brownout_seen = 1'b1;
                    // Restart the hold; a partly spent count is not enough.
                    next_hold_cnt = 8'(HOLD_CYCLES - 1);
                end
                else if (hold_cnt != 8'h00)
                begin
                    next_hold_cnt = hold_cnt - 8'h01;
                end
                else if (!pin_low)
                begin
                    // Stay in reset while the pin is still held low.
                    next_state = RSC_RUN;
                end
            end
            RSC_POR:
            begin
                // Hold the power-on reset until the supply recovers, then
                // run the full hold time; never resume directly.
                if (sources.brownout_condition)
                begin
                    next_hold_cnt = 8'(HOLD_CYCLES - 1);
                end
                else if (hold_cnt != 8'h00)
                begin
                    next_hold_cnt = hold_cnt - 8'h01;
                end
                else
                begin
                    next_state = RSC_RUN;
                    next_cause = '0;
                    next_cause.power_on = brownout_seen;
                    next_brownout_seen = 1'b0;
                end
            end
            default:
            begin
                next_state = RSC_POR;
            end
        endcase
        next_system_reset = (next_state != RSC_RUN);
        next_power_on_reset = (next_state == RSC_POR);
        // Power-up: start as a power-on reset with full hold time.
        if (srst)
        begin
            next_state = RSC_POR;
            next_hold_cnt = 8'(HOLD_CYCLES - 1);
            next_brownout_seen = 1'b1;
            next_cause = '0;
            next_watchdog_irq = 1'b0;
            next_pin_cnt = 8'h00;
            next_system_reset = 1'b1;
            next_power_on_reset = 1'b1;
        end
    end

    // Register stage for the sequencer and all outputs.
    // Every top-level output is taken straight from this stage.
    always_ff @(posedge clk)
    begin
        state <= next_state;
        hold_cnt <= next_hold_cnt;
        pin_cnt <= next_pin_cnt;
        brownout_seen <= next_brownout_seen;
        reset_cause_register <= next_cause;
        watchdog_irq <= next_watchdog_irq;
        system_reset <= next_system_reset;
        power_on_reset <= next_power_on_reset;
    end

endmodule

// ==== hdl/rsc_pkg.sv ====
/*
  Shared constants and carrier types for the reset source control block.
  Assumes a single system clock and a synchronous active-high reset.
*/
package rsc_pkg;

    // ------------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------------

    // Pin low cycles, counted after the synchroniser, that start a reset.
    localparam int unsigned RSC_PIN_LOW_CYCLES = 3;
    // Number of synchroniser stages on the external reset pin.
    localparam int unsigned RSC_SYNC_STAGES = 2;
    // Cycles that the system reset output is held once started.
    localparam int unsigned RSC_HOLD_CYCLES = 16;

    // ------------------------------------------------------------------
    // Reset values and types
    // ------------------------------------------------------------------

    // The option bit reads as 1 when unprogrammed.
    localparam logic RSC_OPTION_UNPROGRAMMED = 1'b1;

    // Sequencer states.
    typedef enum logic [1:0] {
        RSC_RUN = 2'b00,
        RSC_SYS_RESET = 2'b01,
        RSC_POR = 2'b10
    } rsc_state_t;

    // Inputs that can cause a reset or an interrupt.
    typedef struct packed {
        logic ext_reset_n;
        logic watchdog_timeout;
        logic brownout_condition;
        logic normal_or_halt;
    } rsc_sources_t;

    // Reset cause flags.
    typedef struct packed {
        logic power_on;
        logic external;
        logic watchdog_cause_flag;
    } rsc_cause_t;

endpackage

// ==== verif/rsc_checker_asserts.sv ====
/* Assertions on the reset source control ports.
   Assumes binding to rsc_reset_source_control. */
`timescale 1ns/1ns
module rsc_checker_asserts
    import rsc_pkg::*;
#(
    parameter int unsigned PIN_LOW_CYCLES = RSC_PIN_LOW_CYCLES,
    parameter int unsigned HOLD_CYCLES = RSC_HOLD_CYCLES
)
(
    input wire logic clk,
    input wire logic srst,
    input wire rsc_pkg::rsc_sources_t sources,
    input wire logic option_programmed,
    input wire logic option_value,
    input wire logic cause_clear,
    input wire logic system_reset,
    input wire logic power_on_reset,
    input wire logic watchdog_irq,
    input wire rsc_pkg::rsc_cause_t reset_cause_register
);
    // A time-out counts only while no reset is running.
    logic wd_go;
    // An unprogrammed option reads as one.
    logic opt_one;
    assign wd_go = sources.watchdog_timeout && sources.normal_or_halt
        && !system_reset && !power_on_reset && !sources.brownout_condition;
    assign opt_one = !option_programmed || option_value;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // The pin falls while idle and stays low four samples.
    sequence pin_held;
        $fell(sources.ext_reset_n) ##0 !system_reset
            ##1 !sources.ext_reset_n[*3];
    endsequence
    wd_reset_a: assert property (wd_go && opt_one |=> system_reset)
        else $error("watchdog reset missing");
    opt_default_a: assert property (wd_go && !option_programmed
        |=> system_reset && !watchdog_irq) else $error("default option");
    wd_irq_a: assert property (wd_go && !opt_one
        |=> watchdog_irq && !system_reset) else $error("watchdog irq");
    wd_flag_a: assert property (wd_go && opt_one
        |=> reset_cause_register.watchdog_cause_flag) else $error("flag");
    pin_trip_a: assert property (pin_held |-> ##[1:3] system_reset)
        else $error("pin reset late");
    pin_sync_a: assert property ($rose(system_reset)
        && !$past(srst)
        && !$past(sources.watchdog_timeout)
        && !$past(sources.brownout_condition)
        |-> !$past(sources.ext_reset_n, 3) && !$past(sources.ext_reset_n, 5))
        else $error("pin reset early");
    bo_por_a: assert property (sources.brownout_condition
        |=> power_on_reset && system_reset) else $error("brownout");
    bo_hold_a: assert property ($fell(sources.brownout_condition)
        |-> power_on_reset[*8]) else $error("power-on hold");
endmodule
bind rsc_reset_source_control rsc_checker_asserts #(
    .PIN_LOW_CYCLES(PIN_LOW_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) chk (
    .clk(clk), .srst(srst), .sources(sources),
    .option_programmed(option_programmed), .option_value(option_value),
    .cause_clear(cause_clear), .system_reset(system_reset),
    .power_on_reset(power_on_reset), .watchdog_irq(watchdog_irq),
    .reset_cause_register(reset_cause_register));

// ==== verif/rsc_far_side.sv ====
/* Far-side model: external reset circuit and watchdog time-out.
   Assumes bench commands synchronous to clk. */
`timescale 1ns/1ns
module rsc_far_side
(
    input wire logic clk,
    input wire logic srst,
    input wire logic pin_go,
    input wire logic [3:0] pin_len,
    input wire logic wd_go,
    output logic ext_reset_n,
    output logic watchdog_timeout
);
    // Cycles left with the pin held low.
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    // The pull-up returns the pin high when the count runs out.
    always_comb
    begin
        next_cnt = cnt;
        if (srst)
            next_cnt = 4'h0;
        else if (pin_go)
            next_cnt = pin_len;
        else if (cnt != 4'h0)
            next_cnt = cnt - 4'h1;
    end
    always_ff @(posedge clk)
    begin
        cnt <= next_cnt;
        watchdog_timeout <= wd_go;
    end
    assign ext_reset_n = (cnt == 4'h0);
endmodule

// ==== verif/rsc_reset_source_control_test.sv ====
/* Bench for reset source control.
   Assumes the design, its checker and the far-side model. */
`timescale 1ns/1ns
module rsc_reset_source_control_test;
    import rsc_pkg::*;
    // Row: programmed, value, mode, then expected reset and irq.
    typedef struct packed {logic p, v, n, r, i;} rsc_row_t;
    rsc_row_t rows [5] = '{5'h06, 5'h0e, 5'h1e, 5'h15, 5'h18};
    logic clk, srst, bo, nh, pg, pv, cc, pin_go, wd_go, pin_n, wdt;
    logic sr, por, irq;
    logic [3:0] pin_len;
    rsc_sources_t src;
    rsc_cause_t cause;
    int mismatches, n_tests;
    assign src = {pin_n, wdt, bo, nh};
    rsc_reset_source_control dut (.clk(clk), .srst(srst), .sources(src),
        .option_programmed(pg), .option_value(pv), .cause_clear(cc),
        .system_reset(sr), .power_on_reset(por), .watchdog_irq(irq),
        .reset_cause_register(cause));
    rsc_far_side far (.clk(clk), .srst(srst), .pin_go(pin_go),
        .pin_len(pin_len), .wd_go(wd_go), .ext_reset_n(pin_n),
        .watchdog_timeout(wdt));
    task automatic check(string s, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", s, exp, seen);
        end
    endtask
    // Waits, bounded, until no reset output is active.
    task automatic settle();
        int k;
        k = 0;
        while ((sr !== 1'b0 || por !== 1'b0) && k < 100)
        begin
            @(posedge clk);
            k++;
        end
        #1;
        // A reset that never ends runs out the limit and counts here.
        check("settle", {sr, por}, 2'h0);
    endtask
    task automatic pulse_pin(logic [3:0] len);
        @(posedge clk);
        pin_len <= len;
        pin_go <= 1;
        @(posedge clk);
        pin_go <= 0;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    // The whole run needs well under 2500 cycles.
    initial
    begin
        #20000;
        mismatches++;
        summarize();
    end
    initial
    begin
        {srst, bo, nh, pg, pv, cc, pin_go, wd_go, pin_len} = 12'h900;
        repeat (3) @(posedge clk);
        srst <= 0;
        #1;
        check("por", {sr, por, cause}, 5'h18);
        settle();
        check("cause", cause, 3'h4);
        // The clear lands in the same cycle as the time-out: new cause wins.
        foreach (rows[j])
        begin
            @(posedge clk);
            {pg, pv, nh} <= rows[j][4:2];
            wd_go <= 1;
            @(posedge clk);
            wd_go <= 0;
            cc <= 1;
            @(posedge clk);
            cc <= 0;
            #1;
            check("sr", sr, rows[j].r);
            check("irq", irq, rows[j].i);
            check("wdf", cause, {2'b00, rows[j].r});
            settle();
        end
        @(posedge clk);
        nh <= 1;
        // Four-cycle pin hold, then a three-cycle hold, then a dropped glitch.
        pulse_pin(4'h4);
        check("pin", {sr, cause.external}, 2'h3);
        settle();
        pulse_pin(4'h3);
        check("pin3", sr, 1'b1);
        settle();
        pulse_pin(4'h1);
        check("glitch", sr, 1'b0);
        @(posedge clk);
        bo <= 1;
        repeat (2) @(posedge clk);
        bo <= 0;
        repeat (4) @(posedge clk);
        #1;
        check("hold", por, 1);
        settle();
        check("cause", cause, 3'h4);
        // A second reset in mid-run returns to the power-on state.
        @(posedge clk);
        srst <= 1;
        @(posedge clk);
        srst <= 0;
        #1;
        check("rst2", {sr, por, cause}, 5'h18);
        settle();
        check("cause2", cause, 3'h4);
        summarize();
    end
endmodule
